// ---- pkg/rtc_pkg.sv ----
`default_nettype none
package rtc_pkg;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int WDT_TICK_NS   = 714000;
   localparam int WDT_TICK_CYC  = WDT_TICK_NS / CLK_PERIOD_NS;
   localparam int INSTR_DIV_DEF = 4;

   // -------------------------------------------------------------
   // Widths and values
   // -------------------------------------------------------------
   localparam int         ADDR_W    = 4;
   localparam int         COUNT_W   = 8;
   localparam int         SCALE_W   = 8;
   localparam int         IRQ_W     = 2;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_RST = 8'h00;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [3:0] ADDR_COUNT         = 4'h0;
   localparam logic [3:0] ADDR_OPTION        = 4'h1;
   localparam logic [3:0] ADDR_TIMER1_CTRL_B = 4'h2;
   localparam logic [3:0] ADDR_IRQ_STAT      = 4'h3;
   localparam logic [3:0] ADDR_IRQ_MASK      = 4'h4;
   localparam logic [3:0] ADDR_WDT_CLR       = 4'h5;

   // -------------------------------------------------------------
   // Option fields
   // -------------------------------------------------------------
   localparam int         OPT_SEL_LSB = 0;
   localparam int         OPT_SEL_MSB = 2;
   localparam int         OPT_ASSIGN  = 3;
   localparam int         OPT_EDGE    = 4;
   localparam int         OPT_SRC     = 5;
   localparam int         OPT_IE_N    = 6;
   localparam logic [6:0] OPTION_RST  = 7'h7F;
   localparam int         PEND_BIT    = 7;
   localparam int         IRQ_ROLL    = 0;
   localparam int         IRQ_PIN     = 1;

   // Count source encoding
   typedef enum logic {
      RTC_SRC_INSTR = 1'b0,
      RTC_SRC_PIN   = 1'b1
   } rtc_src_t;

endpackage
`default_nettype wire

// ---- hdl/rtc_pin_edge.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtc_pin_edge
   import rtc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Pin and control
   input  wire logic pin_in,
   input  wire logic pin_edge_sel,
   // Event out
   output logic      edge_pulse
);

   logic sync1_q;
   logic sync2_q;
   logic last_q;

   // -------------------------------------------------------------
   // Synchroniser and edge detect
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         last_q  <= 1'b0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         last_q  <= sync2_q;
      end
   end

   // 0 rising, 1 falling
   assign edge_pulse = pin_edge_sel ? (last_q & ~sync2_q)
                                    : (~last_q & sync2_q);

   a_edge_single: assert property (@(posedge clk) disable iff (!resetn)
      edge_pulse |=> !edge_pulse)
      else $error("pin edge pulse longer than one cycle");

endmodule
`default_nettype wire

// ---- hdl/rtc_watchdog.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtc_watchdog
   import rtc_pkg::*;
#(
   parameter int TICK_CYC = WDT_TICK_CYC
)(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          resetn,
   // Control
   input  wire logic          wdt_enable,
   input  wire logic          wdt_clear,
   // Status
   output logic               wdt_ovf,
   output logic [COUNT_W-1:0] wdt_count_q
);

   logic [15:0] tick_q;
   logic        tick;

   if (TICK_CYC < 1 || TICK_CYC > 65536) begin : g_chk
      $error("watchdog tick count out of range");
   end

   // -------------------------------------------------------------
   // Stand-in for the separate watchdog oscillator
   // -------------------------------------------------------------
   assign tick = wdt_enable && (tick_q == 16'(TICK_CYC - 1));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_q <= 16'h0000;
      end else if (wdt_clear || !wdt_enable || tick) begin
         tick_q <= 16'h0000;
      end else begin
         tick_q <= tick_q + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdt_count_q <= COUNT_RST;
      end else if (wdt_clear) begin
         wdt_count_q <= COUNT_RST;
      end else if (tick) begin
         wdt_count_q <= wdt_count_q + 8'h01;
      end
   end

   assign wdt_ovf = tick && (wdt_count_q == COUNT_MAX);

endmodule
`default_nettype wire

// ---- hdl/rtc_core.sv ----
// What this block does
// - Software reads and writes an 8-bit count register of 256 states.
// - Source select bit: 1 counts pin events, 0 counts instruction cycles.
// - Pin edge select: 0 counts rising edges, 1 counts falling edges.
// - One 8-bit scaler serves either the counter or the watchdog, never both.
// - Source events advance the scaler; counter steps on a chosen scaler bit.
// - Largest division is 256, giving a span of 65536 events.
// - Unscaled instruction source: counter steps every instruction cycle.
// - Rollover FFh to 00h requests interrupt only while enable_n is 0.
// - A written count becomes the new start and counting continues upward.
// - In power-down counting stops and the count is not to be trusted.
// - Watchdog overflow, after postscaling, gives a device reset.
// - At most one external event counted per instruction cycle.
// - Scaler on watchdog: codes 000 to 111 give factors 1 to 128.
// - Pending flag at bit 7 of timer1 control B records rollovers.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module rtc_core
   import rtc_pkg::*;
#(
   parameter int INSTR_DIV = INSTR_DIV_DEF,
   parameter int WDT_TICK  = WDT_TICK_CYC
)(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   // Pins and core controls
   input  wire logic              count_pin,
   input  wire logic              sleep_req,
   input  wire logic              wdt_enable,
   // Outputs
   output logic                   irq,
   output logic                   wdt_reset_req
);

   logic [7:0]         divcnt_q;
   logic               instr_en;
   logic [COUNT_W-1:0] rt_counter_q;
   logic [SCALE_W-1:0] scaler_q;
   logic [6:0]         option_q;
   logic               overflow_pending_flag_q;
   logic [IRQ_W-1:0]   irq_stat_q;
   logic [IRQ_W-1:0]   irq_mask_q;
   logic               evt_seen_q;
   logic               wdt_reset_q;
   logic [7:0]         rdata_q;
   logic               pin_evt;
   logic               src_evt;
   logic               cnt_step;
   logic               rollover;
   logic               wr_count;
   logic               wdt_clear;
   logic               wdt_ovf;
   logic               wdt_fire;
   logic [7:0]         pre_mask;
   logic [7:0]         post_mask;
   logic [2:0]         scale_factor_sel;
   logic               scaler_assign;
   logic               pin_edge_sel;
   logic               overflow_irq_enable_n;
   rtc_src_t           count_src;

   if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_chk
      $error("INSTR_DIV out of range");
   end

   assign scale_factor_sel      = option_q[OPT_SEL_MSB:OPT_SEL_LSB];
   assign scaler_assign         = option_q[OPT_ASSIGN];
   assign pin_edge_sel          = option_q[OPT_EDGE];
   assign overflow_irq_enable_n = option_q[OPT_IE_N];
   assign count_src             = rtc_src_t'(option_q[OPT_SRC]);
   assign wr_count              = reg_wr && (reg_addr == ADDR_COUNT);
   assign wdt_clear             = reg_wr && (reg_addr == ADDR_WDT_CLR);

   // -------------------------------------------------------------
   // Instruction cycle enable
   // -------------------------------------------------------------
   // Held in sleep: stands for the stopped device clock
   assign instr_en = !sleep_req && (divcnt_q == 8'(INSTR_DIV - 1));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         divcnt_q <= 8'h00;
      end else if (sleep_req || instr_en) begin
         divcnt_q <= 8'h00;
      end else begin
         divcnt_q <= divcnt_q + 8'h01;
      end
   end

   // -------------------------------------------------------------
   // Pin events, one per instruction cycle
   // -------------------------------------------------------------
   rtc_pin_edge u_pin (
      .clk          (clk),
      .resetn       (resetn),
      .pin_in       (count_pin),
      .pin_edge_sel (pin_edge_sel),
      .edge_pulse   (pin_evt)
   );

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         evt_seen_q <= 1'b0;
      end else if (sleep_req || instr_en) begin
         evt_seen_q <= 1'b0;
      end else if (pin_evt) begin
         evt_seen_q <= 1'b1;
      end
   end

   // Extra edges inside one cycle merge into the latch
   assign src_evt = instr_en && ((count_src == RTC_SRC_INSTR)
                                 || pin_evt || evt_seen_q);

   // -------------------------------------------------------------
   // Scaler
   // -------------------------------------------------------------
   assign pre_mask  = ~(8'hFE << scale_factor_sel);
   assign post_mask = ~(8'hFF << scale_factor_sel);
   assign cnt_step  = src_evt && (scaler_assign ||
                      ((scaler_q & pre_mask) == pre_mask));
   assign wdt_fire  = wdt_ovf && (!scaler_assign ||
                      ((scaler_q & post_mask) == post_mask));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scaler_q <= 8'h00;
      end else if (wdt_clear) begin
         scaler_q <= 8'h00;
      end else if (!scaler_assign && src_evt) begin
         scaler_q <= scaler_q + 8'h01;
      end else if (scaler_assign && wdt_ovf) begin
         scaler_q <= scaler_q + 8'h01;
      end
   end

   // -------------------------------------------------------------
   // Counter
   // -------------------------------------------------------------
   assign rollover = cnt_step && !wr_count && (rt_counter_q == COUNT_MAX);

   // Write wins over a step in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rt_counter_q <= COUNT_RST;
      end else if (wr_count) begin
         rt_counter_q <= reg_wdata;
      end else if (cnt_step) begin
         rt_counter_q <= rt_counter_q + 8'h01;
      end
   end

   // -------------------------------------------------------------
   // Watchdog
   // -------------------------------------------------------------
   rtc_watchdog #(
      .TICK_CYC (WDT_TICK)
   ) u_wdt (
      .clk         (clk),
      .resetn      (resetn),
      .wdt_enable  (wdt_enable),
      .wdt_clear   (wdt_clear),
      .wdt_ovf     (wdt_ovf),
      .wdt_count_q ()
   );

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdt_reset_q <= 1'b0;
      end else begin
         wdt_reset_q <= wdt_fire;
      end
   end

   assign wdt_reset_req = wdt_reset_q;

   // -------------------------------------------------------------
   // Option and interrupt registers
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         option_q <= OPTION_RST;
      end else if (reg_wr && reg_addr == ADDR_OPTION) begin
         option_q <= reg_wdata[6:0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_mask_q <= '0;
      end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
         irq_mask_q <= reg_wdata[IRQ_W-1:0];
      end
   end

   // Set beats a write-one clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         overflow_pending_flag_q <= 1'b0;
      end else if (rollover) begin
         overflow_pending_flag_q <= 1'b1;
      end else if (reg_wr && reg_addr == ADDR_TIMER1_CTRL_B
                   && reg_wdata[PEND_BIT]) begin
         overflow_pending_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q[IRQ_ROLL] <= (rollover && !overflow_irq_enable_n)
            || (irq_stat_q[IRQ_ROLL] && !(reg_wr
            && reg_addr == ADDR_IRQ_STAT && reg_wdata[IRQ_ROLL]));
         irq_stat_q[IRQ_PIN] <= pin_evt
            || (irq_stat_q[IRQ_PIN] && !(reg_wr
            && reg_addr == ADDR_IRQ_STAT && reg_wdata[IRQ_PIN]));
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // -------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_COUNT:         rdata_q <= rt_counter_q;
            ADDR_OPTION:        rdata_q <= {1'b0, option_q};
            ADDR_TIMER1_CTRL_B: rdata_q <= {overflow_pending_flag_q, 7'h00};
            ADDR_IRQ_STAT:      rdata_q <= {6'h00, irq_stat_q};
            ADDR_IRQ_MASK:      rdata_q <= {6'h00, irq_mask_q};
            default:            rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_instr_step;
      src_evt && scaler_assign && !wr_count;
   endsequence

   sequence s_wrap;
      rollover && !overflow_irq_enable_n;
   endsequence

   a_load_value: assert property (
      wr_count |=> rt_counter_q == $past(reg_wdata))
      else $error("written count not loaded");

   a_unscaled_step: assert property (
      s_instr_step |=> rt_counter_q == $past(rt_counter_q) + 8'h01)
      else $error("unscaled step not plus one");

   a_hold_between: assert property (
      !instr_en && !wr_count |=> $stable(rt_counter_q))
      else $error("count moved outside instruction cycle");

   a_pin_idle: assert property (
      count_src == RTC_SRC_PIN && !pin_evt && !evt_seen_q && !wr_count
      |=> $stable(rt_counter_q))
      else $error("pin source counted without an edge");

   a_sleep_hold: assert property (
      sleep_req && !wr_count |=> $stable(rt_counter_q))
      else $error("count moved in power-down");

   a_wrap_irq: assert property (
      s_wrap ##1 irq_mask_q[IRQ_ROLL] |-> irq)
      else $error("rollover interrupt missing");

   a_wrap_masked: assert property (
      rollover && overflow_irq_enable_n && !irq_stat_q[IRQ_ROLL]
      |=> !irq_stat_q[IRQ_ROLL])
      else $error("rollover flagged while disabled");

   a_wrap_pending: assert property (
      rollover |=> overflow_pending_flag_q && rt_counter_q == COUNT_RST)
      else $error("rollover not recorded");

   a_scaler_owned: assert property (
      scaler_assign && !wdt_ovf && !wdt_clear |=> $stable(scaler_q))
      else $error("scaler moved while owned by watchdog");

   a_prescale_step: assert property (
      src_evt && !scaler_assign && !wr_count
      && (scaler_q & pre_mask) != pre_mask
      |=> $stable(rt_counter_q))
      else $error("counter stepped before scaler bit");

   a_wdt_reset: assert property (
      wdt_ovf && !scaler_assign |=> wdt_reset_req ##1 !wdt_reset_req)
      else $error("watchdog reset pulse wrong");

endmodule
`default_nettype wire

// ---- verification/rtc_pulse_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtc_pulse_src (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Request
   input  wire logic       start,
   input  wire logic [7:0] n_pulses,
   input  wire logic [7:0] half_cyc,
   // Pin side
   output logic            pin,
   output logic            busy
);
   logic [7:0] left_q;
   logic [7:0] tick_q;

   assign busy = (left_q != 8'h00);

   // Pin idles low; each pulse is a low then a high phase of half_cyc
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         left_q <= 8'h00;
         tick_q <= 8'h00;
         pin    <= 1'b0;
      end else if (start && !busy) begin
         left_q <= n_pulses;
         tick_q <= 8'h00;
         pin    <= 1'b0;
      end else if (busy) begin
         if (tick_q == half_cyc - 8'h01) begin
            tick_q <= 8'h00;
            pin    <= ~pin;
            if (pin) begin
               left_q <= left_q - 8'h01;
            end
         end else begin
            tick_q <= tick_q + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import rtc_pkg::*;
   localparam int TICK = 4;
   logic       clk;
   logic       resetn;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       count_pin;
   logic       sleep_req;
   logic       wdt_enable;
   logic       irq;
   logic       wdt_reset_req;
   logic       start;
   logic [7:0] n_pulses;
   logic [7:0] half_cyc;
   logic       busy;
   int         n_mismatch;
   int         checks_done;
   int         seed;

   rtc_core #(.INSTR_DIV(4), .WDT_TICK(TICK)) uut (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .count_pin(count_pin),
      .sleep_req(sleep_req), .wdt_enable(wdt_enable), .irq(irq),
      .wdt_reset_req(wdt_reset_req));

   rtc_pulse_src src (
      .clk(clk), .resetn(resetn), .start(start), .n_pulses(n_pulses),
      .half_cyc(half_cyc), .pin(count_pin), .busy(busy));

   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   function automatic logic [7:0] opt(input logic [2:0] s,
      input logic a, input logic e, input logic sr, input logic ie);
      opt = {1'b0, ie, sr, e, a, s};
   endfunction

   function automatic logic [7:0] in_rng(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      in_rng = {7'h00, (v >= lo) && (v <= hi)};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic pulses(input logic [7:0] n, input logic [7:0] h);
      int k;
      @(posedge clk);
      start    <= 1'b1;
      n_pulses <= n;
      half_cyc <= h;
      @(posedge clk);
      start    <= 1'b0;
      k = 0;
      while (!busy && k < 4) begin
         @(posedge clk);
         k++;
      end
   endtask

   task automatic roll(input logic [7:0] o, input logic [7:0] m,
      input logic st, input logic iq);
      logic [7:0] v;
      wr(ADDR_IRQ_MASK, m);
      wr(ADDR_OPTION, o);
      wr(ADDR_COUNT, 8'hFD);
      cyc(24);
      rd(ADDR_IRQ_STAT, v);
      check({7'h00, v[IRQ_ROLL]}, {7'h00, st});
      check({7'h00, irq}, {7'h00, iq});
      rd(ADDR_TIMER1_CTRL_B, v);
      check({7'h00, v[PEND_BIT]}, 8'h01);
      rd(ADDR_COUNT, v);
      check(in_rng({8'h00, v}, 16'h0, 16'h8), 8'h01);
      wr(ADDR_IRQ_STAT, 8'hFF);
      wr(ADDR_TIMER1_CTRL_B, 8'h80);
      cyc(2);
      check({7'h00, irq}, 8'h00);
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Hang guard, well above the expected run of some 11000 cycles
   initial begin
      #1000000;
      n_mismatch++;
      wrap_up();
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      logic [7:0] v;
      logic [7:0] a;
      logic [7:0] o [3];
      int         f [3];
      int         n;
      seed = 15;
      n_mismatch = 0;
      checks_done = 0;
      resetn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sleep_req = 1'b0;
      wdt_enable = 1'b0;
      start = 1'b0;
      n_pulses = 8'h00;
      half_cyc = 8'h01;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rd(ADDR_COUNT, v);
      check(v, COUNT_RST);
      rd(ADDR_OPTION, v);
      check(v, {1'b0, OPTION_RST});
      rd(ADDR_IRQ_MASK, v);
      check(v, 8'h00);
      rd(4'hA, v);
      check(v, 8'h00);
      // Pin source at reset with idle pin: count must hold writes
      repeat (4) begin
         a = 8'($random(seed));
         wr(ADDR_COUNT, a);
         rd(ADDR_COUNT, v);
         check(v, a);
      end
      wr(ADDR_OPTION, opt(3'h0, 1'b1, 1'b0, 1'b0, 1'b0));
      wr(ADDR_COUNT, 8'h10);
      cyc(80);
      rd(ADDR_COUNT, v);
      check(in_rng({8'h00, v}, 16'h22, 16'h26), 8'h01);
      roll(8'h08, 8'h01, 1'b1, 1'b1);
      roll(8'h08, 8'h00, 1'b1, 1'b0);
      roll(8'h48, 8'h01, 1'b0, 1'b0);
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_OPTION, opt(s[2:0], 1'b0, 1'b0, 1'b0, 1'b1));
         wr(ADDR_COUNT, 8'h00);
         cyc(4 * (2 << s) * 3);
         rd(ADDR_COUNT, v);
         check(in_rng({8'h00, v}, 16'h3, 16'h4), 8'h01);
      end
      // One long pulse: only the selected edge counts mid-pulse
      for (int e = 0; e < 2; e++) begin
         wr(ADDR_OPTION, opt(3'h0, 1'b1, e[0], 1'b1, 1'b1));
         wr(ADDR_COUNT, 8'h00);
         pulses(8'h01, 8'd40);
         cyc(60);
         rd(ADDR_COUNT, v);
         check(v, (e == 0) ? 8'h01 : 8'h00);
         n = 0;
         while (busy && n < 200) begin
            cyc(1);
            n++;
         end
         cyc(10);
         rd(ADDR_COUNT, v);
         check(v, 8'h01);
      end
      wr(ADDR_OPTION, opt(3'h0, 1'b1, 1'b0, 1'b1, 1'b1));
      repeat (3) begin
         a = (8'($random(seed)) & 8'h0F) + 8'h01;
         wr(ADDR_COUNT, 8'h00);
         pulses(a, 8'd6);
         cyc(14 * a + 10);
         rd(ADDR_COUNT, v);
         check(v, a);
      end
      // Pin edge flag, its mask and its write-one clear
      wr(ADDR_IRQ_MASK, 8'h02);
      rd(ADDR_IRQ_STAT, v);
      check({7'h00, v[IRQ_PIN]}, 8'h01);
      check({7'h00, irq}, 8'h01);
      wr(ADDR_IRQ_STAT, 8'h02);
      wr(ADDR_IRQ_MASK, 8'h01);
      rd(ADDR_IRQ_STAT, v);
      check({7'h00, v[IRQ_PIN]}, 8'h00);
      check({7'h00, irq}, 8'h00);
      // Edges faster than the instruction rate merge
      wr(ADDR_COUNT, 8'h00);
      pulses(8'd10, 8'd1);
      cyc(30);
      rd(ADDR_COUNT, v);
      check(in_rng({8'h00, v}, 16'h1, 16'h6), 8'h01);
      wr(ADDR_OPTION, 8'h48);
      sleep_req <= 1'b1;
      rd(ADDR_COUNT, a);
      cyc(40);
      rd(ADDR_COUNT, v);
      check(v, a);
      @(posedge clk);
      sleep_req <= 1'b0;
      cyc(40);
      rd(ADDR_COUNT, v);
      check({7'h00, v != a}, 8'h01);
      // Watchdog period against scaler assignment and factor
      o[0] = 8'h48;
      o[1] = 8'h49;
      o[2] = 8'h47;
      f[0] = 1;
      f[1] = 2;
      f[2] = 1;
      @(posedge clk);
      wdt_enable <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_OPTION, o[i]);
         wr(ADDR_WDT_CLR, 8'h00);
         n = 0;
         while (wdt_reset_req !== 1'b1 && n < 5000) begin
            cyc(1);
            n++;
         end
         check(in_rng(16'(n), 16'(256 * TICK * f[i] - 24),
            16'(256 * TICK * f[i] + 24)), 8'h01);
      end
      @(posedge clk);
      wdt_enable <= 1'b0;
      cyc(4);
      check({7'h00, irq}, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
